//--- rtl/stat_inc_defs.vh
// Constants for the statistics increment pulse logic
`ifndef STAT_INC_DEFS_VH
`define STAT_INC_DEFS_VH

// ==========================================================
// Frame length thresholds in bytes
`define LEN_W           16
`define LEN_64          16'h0040
`define LEN_127         16'h007F
`define LEN_255         16'h00FF
`define LEN_511         16'h01FF
`define LEN_1023        16'h03FF
`define LEN_1518        16'h05EE
`define MAX_LEN_RESET   16'h05EE

// ==========================================================
// Bit positions in the increment vector
`define INC_W           23
`define INC_64          0
`define INC_127         1
`define INC_255         2
`define INC_511         3
`define INC_1023        4
`define INC_1518        5
`define INC_MAX         6
`define INC_OVER        7
`define INC_MDATA_ERR   8
`define INC_MDATA_OK    9
`define INC_BDATA_ERR   10
`define INC_BDATA_OK    11
`define INC_UDATA_ERR   12
`define INC_UDATA_OK    13
`define INC_MVALID      14
`define INC_BVALID      15
`define INC_UVALID      16
`define INC_PAUSE       17
`define INC_FCS         18
`define INC_FRAGMENT    19
`define INC_JABBER      20
`define INC_SIZEOK_FCS  21
`define INC_RUNT        22

`endif

//--- rtl/mac_statistics_increment_pulses.v
// Frame classification into one-cycle statistics increment pulses
// How it works
// - TX errored multicast non-control frame gives one-cycle multicast-error pulse.
// - TX good multicast non-control frame gives one-cycle multicast-good-data pulse.
// - TX errored broadcast non-control frame gives one-cycle broadcast-error pulse.
// - TX good broadcast non-control frame gives one-cycle broadcast-good-data pulse.
// - TX errored unicast non-control frame gives one-cycle unicast-error pulse.
// - TX good unicast non-control frame gives one-cycle unicast-good-data pulse.
// - TX good multicast, broadcast, unicast pulses, control frames included.
// - TX good pause frame gives one-cycle pause pulse.
// - TX frame with check sequence error gives one-cycle error pulse.
// - TX frame under 64 bytes with CRC error gives fragment pulse.
// - TX oversized frame with CRC error gives jabber pulse.
// - TX valid-length frame with check error gives size-ok-error pulse.
// - RX runt packet gives one-cycle runt pulse.
// - RX frame pulses its one size bucket, 64 up to 1518 bytes.
// - RX frame of configured maximum size gives maximum-size pulse.
// - RX frame longer than maximum gives oversize pulse.
// - RX errored multicast non-control frame gives multicast-error pulse.
// - RX good multicast non-control frame gives multicast-good-data pulse.
// - RX errored broadcast or unicast non-control frame gives its error pulse.
// - RX good broadcast non-control frame gives broadcast-good-data pulse.
// - RX good unicast non-control frame gives unicast-good-data pulse.
// - RX good multicast and broadcast pulses, control frames included.
// - TX and RX pulses are both synchronous to the one clock, clk_sys.
// - TX frame pulses its size bucket, maximum-size or oversize.
// - Pulses are top-level outputs, also usable by counter registers.
`timescale 1ns/1ps
`include "stat_inc_defs.vh"

// ==========================================================
// Classifier shared by the TX and RX paths
module frame_classifier
(
  input  wire                  clk_sys,
  input  wire                  reset_n,
  // Frame-end descriptor
  input  wire                  done,
  input  wire [`LEN_W-1:0]     len,
  input  wire                  err,
  input  wire                  mcast,
  input  wire                  bcast,
  input  wire                  ctrl,
  input  wire                  pause,
  // Configured maximum, same clock
  input  wire [`LEN_W-1:0]     max_len,
  // One bit per statistic
  output reg  [`INC_W-1:0]     inc_r
);

  reg  [`INC_W-1:0] inc_nxt;
  // Destination class
  wire              is_bcast;
  wire              is_mcast;
  wire              is_ucast;
  // Frame qualifiers
  wire              good;
  wire              data;
  wire              short;
  wire              over;
  wire              at_max;
  // Shared length thresholds
  wire              above_64;
  wire              above_127;
  wire              above_255;
  wire              above_511;
  wire              above_1023;
  wire              above_1518;
  // Length buckets
  wire              in_64;
  wire              in_127;
  wire              in_255;
  wire              in_511;
  wire              in_1023;
  wire              in_1518;
  // Class against error
  wire              mdata_err;
  wire              mdata_ok;
  wire              bdata_err;
  wire              bdata_ok;
  wire              udata_err;
  wire              udata_ok;
  wire              mvalid;
  wire              bvalid;
  wire              uvalid;
  // Error classes by length
  wire              pause_ok;
  wire              fragment;
  wire              jabber;
  wire              sizeok_err;

  // ==========================================================
  // Destination class
  // Broadcast also carries the group bit; counted as broadcast only
  assign is_bcast = bcast;
  assign is_mcast = mcast & ~bcast;
  assign is_ucast = ~mcast & ~bcast;

  // ==========================================================
  // Frame qualifiers
  assign good   = ~err;
  assign data   = ~ctrl;
  assign short  = (len < `LEN_64);
  assign over   = (len > max_len);
  // Not exclusive: the maximum may share a cycle with a bucket
  assign at_max = (len == max_len);

  // ==========================================================
  // Length buckets
  // Each threshold is compared once; 127 to 1023 are shared by two neighbours
  assign above_64   = (len > `LEN_64);
  assign above_127  = (len > `LEN_127);
  assign above_255  = (len > `LEN_255);
  assign above_511  = (len > `LEN_511);
  assign above_1023 = (len > `LEN_1023);
  assign above_1518 = (len > `LEN_1518);
  // Below 64 or past 1518 no bucket fires at all
  assign in_64   = (len == `LEN_64);
  assign in_127  = above_64   & ~above_127;
  assign in_255  = above_127  & ~above_255;
  assign in_511  = above_255  & ~above_511;
  assign in_1023 = above_511  & ~above_1023;
  assign in_1518 = above_1023 & ~above_1518;

  // ==========================================================
  // Class against error
  // The data set leaves control frames out
  assign mdata_err = is_mcast & err  & data;
  assign mdata_ok  = is_mcast & good & data;
  assign bdata_err = is_bcast & err  & data;
  assign bdata_ok  = is_bcast & good & data;
  assign udata_err = is_ucast & err  & data;
  assign udata_ok  = is_ucast & good & data;
  // The valid set counts control frames as well
  assign mvalid    = is_mcast & good;
  assign bvalid    = is_bcast & good;
  assign uvalid    = is_ucast & good;

  // ==========================================================
  // Error classes by length
  assign pause_ok   = pause & good;
  assign fragment   = short & err;
  assign jabber     = over & err;
  // Fragment and jabber take the two ends, this the middle
  assign sizeok_err = ~short & ~over & err;

  // ==========================================================
  // Gather; the vector stays quiet unless a frame ends
  always @*
  begin
    inc_nxt = {`INC_W{1'b0}};
    if (done)
    begin
      // Size buckets are disjoint so at most one fires
      inc_nxt[`INC_64]         = in_64;
      inc_nxt[`INC_127]        = in_127;
      inc_nxt[`INC_255]        = in_255;
      inc_nxt[`INC_511]        = in_511;
      inc_nxt[`INC_1023]       = in_1023;
      inc_nxt[`INC_1518]       = in_1518;
      inc_nxt[`INC_MAX]        = at_max;
      inc_nxt[`INC_OVER]       = over;
      inc_nxt[`INC_MDATA_ERR]  = mdata_err;
      inc_nxt[`INC_MDATA_OK]   = mdata_ok;
      inc_nxt[`INC_BDATA_ERR]  = bdata_err;
      inc_nxt[`INC_BDATA_OK]   = bdata_ok;
      inc_nxt[`INC_UDATA_ERR]  = udata_err;
      inc_nxt[`INC_UDATA_OK]   = udata_ok;
      inc_nxt[`INC_MVALID]     = mvalid;
      inc_nxt[`INC_BVALID]     = bvalid;
      inc_nxt[`INC_UVALID]     = uvalid;
      inc_nxt[`INC_PAUSE]      = pause_ok;
      inc_nxt[`INC_FCS]        = err;
      inc_nxt[`INC_FRAGMENT]   = fragment;
      inc_nxt[`INC_JABBER]     = jabber;
      inc_nxt[`INC_SIZEOK_FCS] = sizeok_err;
      // Runt counted on length alone; fragment also needs a bad CRC
      inc_nxt[`INC_RUNT]       = short;
    end
  end

  // Registered every cycle: each frame end sets its bits for exactly one cycle
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      inc_r <= {`INC_W{1'b0}};
    else
      inc_r <= inc_nxt;
  end

endmodule

// ==========================================================
// Top level: TX and RX increment vectors
module mac_statistics_increment_pulses
(
  input  wire                  clk_sys,
  input  wire                  reset_n,
  input  wire [`LEN_W-1:0]     max_frame_len,
  // TX frame-end descriptor
  input  wire                  tx_frame_done,
  input  wire [`LEN_W-1:0]     tx_frame_len,
  input  wire                  tx_frame_err,
  input  wire                  tx_dest_mcast,
  input  wire                  tx_dest_bcast,
  input  wire                  tx_frame_ctrl,
  input  wire                  tx_frame_pause,
  // RX frame-end descriptor
  input  wire                  rx_frame_done,
  input  wire [`LEN_W-1:0]     rx_frame_len,
  input  wire                  rx_frame_err,
  input  wire                  rx_dest_mcast,
  input  wire                  rx_dest_bcast,
  input  wire                  rx_frame_ctrl,
  // TX increment pulses
  output wire                  tx_inc_64,
  output wire                  tx_inc_127,
  output wire                  tx_inc_255,
  output wire                  tx_inc_511,
  output wire                  tx_inc_1023,
  output wire                  tx_inc_1518,
  output wire                  tx_inc_max,
  output wire                  tx_inc_over,
  output wire                  tx_inc_mcast_data_err,
  output wire                  tx_inc_mcast_data_ok,
  output wire                  tx_inc_bcast_data_err,
  output wire                  tx_inc_bcast_data_ok,
  output wire                  tx_inc_ucast_data_err,
  output wire                  tx_inc_ucast_data_ok,
  output wire                  tx_inc_mcast_ctrl,
  output wire                  tx_inc_bcast_ctrl,
  output wire                  tx_inc_ucast_ctrl,
  output wire                  tx_inc_pause,
  output wire                  tx_inc_fcs_err,
  output wire                  tx_inc_fragment,
  output wire                  tx_inc_jabber,
  output wire                  tx_inc_sizeok_fcser,
  // RX increment pulses
  output wire                  rx_inc_runt,
  output wire                  rx_inc_64,
  output wire                  rx_inc_127,
  output wire                  rx_inc_255,
  output wire                  rx_inc_511,
  output wire                  rx_inc_1023,
  output wire                  rx_inc_1518,
  output wire                  rx_inc_max,
  output wire                  rx_inc_over,
  output wire                  rx_inc_mcast_data_err,
  output wire                  rx_inc_mcast_data_ok,
  output wire                  rx_inc_bcast_data_err,
  output wire                  rx_inc_bcast_data_ok,
  output wire                  rx_inc_ucast_data_err,
  output wire                  rx_inc_ucast_data_ok,
  output wire                  rx_inc_mcast_ctrl,
  output wire                  rx_inc_bcast_ctrl
);

  wire [`INC_W-1:0] tx_inc;
  wire [`INC_W-1:0] rx_inc;

  // ==========================================================
  // Classifiers; one clock here, so both sets share clk_sys
  frame_classifier u_tx_class
  (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .done    (tx_frame_done),
    .len     (tx_frame_len),
    .err     (tx_frame_err),
    .mcast   (tx_dest_mcast),
    .bcast   (tx_dest_bcast),
    .ctrl    (tx_frame_ctrl),
    .pause   (tx_frame_pause),
    .max_len (max_frame_len),
    .inc_r   (tx_inc)
  );

  // Pause pulses are not part of the RX set handled here
  frame_classifier u_rx_class
  (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .done    (rx_frame_done),
    .len     (rx_frame_len),
    .err     (rx_frame_err),
    .mcast   (rx_dest_mcast),
    .bcast   (rx_dest_bcast),
    .ctrl    (rx_frame_ctrl),
    .pause   (1'b0),
    .max_len (max_frame_len),
    .inc_r   (rx_inc)
  );

  // ==========================================================
  // Vector to named outputs; counter registers may tap the same wires
  assign tx_inc_64             = tx_inc[`INC_64];
  assign tx_inc_127            = tx_inc[`INC_127];
  assign tx_inc_255            = tx_inc[`INC_255];
  assign tx_inc_511            = tx_inc[`INC_511];
  assign tx_inc_1023           = tx_inc[`INC_1023];
  assign tx_inc_1518           = tx_inc[`INC_1518];
  assign tx_inc_max            = tx_inc[`INC_MAX];
  assign tx_inc_over           = tx_inc[`INC_OVER];

  // ==========================================================
  // TX class set
  assign tx_inc_mcast_data_err = tx_inc[`INC_MDATA_ERR];
  assign tx_inc_mcast_data_ok  = tx_inc[`INC_MDATA_OK];
  assign tx_inc_bcast_data_err = tx_inc[`INC_BDATA_ERR];
  assign tx_inc_bcast_data_ok  = tx_inc[`INC_BDATA_OK];
  assign tx_inc_ucast_data_err = tx_inc[`INC_UDATA_ERR];
  assign tx_inc_ucast_data_ok  = tx_inc[`INC_UDATA_OK];
  assign tx_inc_mcast_ctrl     = tx_inc[`INC_MVALID];
  assign tx_inc_bcast_ctrl     = tx_inc[`INC_BVALID];
  assign tx_inc_ucast_ctrl     = tx_inc[`INC_UVALID];

  // ==========================================================
  // TX error and pause set
  assign tx_inc_pause          = tx_inc[`INC_PAUSE];
  assign tx_inc_fcs_err        = tx_inc[`INC_FCS];
  assign tx_inc_fragment       = tx_inc[`INC_FRAGMENT];
  assign tx_inc_jabber         = tx_inc[`INC_JABBER];
  assign tx_inc_sizeok_fcser   = tx_inc[`INC_SIZEOK_FCS];

  // ==========================================================
  // RX size set
  assign rx_inc_runt           = rx_inc[`INC_RUNT];
  assign rx_inc_64             = rx_inc[`INC_64];
  assign rx_inc_127            = rx_inc[`INC_127];
  assign rx_inc_255            = rx_inc[`INC_255];
  assign rx_inc_511            = rx_inc[`INC_511];
  assign rx_inc_1023           = rx_inc[`INC_1023];
  assign rx_inc_1518           = rx_inc[`INC_1518];
  assign rx_inc_max            = rx_inc[`INC_MAX];
  assign rx_inc_over           = rx_inc[`INC_OVER];

  // ==========================================================
  // RX class set
  assign rx_inc_mcast_data_err = rx_inc[`INC_MDATA_ERR];
  assign rx_inc_mcast_data_ok  = rx_inc[`INC_MDATA_OK];
  assign rx_inc_bcast_data_err = rx_inc[`INC_BDATA_ERR];
  assign rx_inc_bcast_data_ok  = rx_inc[`INC_BDATA_OK];
  assign rx_inc_ucast_data_err = rx_inc[`INC_UDATA_ERR];
  assign rx_inc_ucast_data_ok  = rx_inc[`INC_UDATA_OK];
  assign rx_inc_mcast_ctrl     = rx_inc[`INC_MVALID];
  assign rx_inc_bcast_ctrl     = rx_inc[`INC_BVALID];

endmodule

//--- dv/stat_pulse_checker.sv
// Assertions on the statistics increment pulse outputs
`timescale 1ns/1ps

// ==========================================================
// Checker
module stat_pulse_checker
(
  input logic        clk_sys,
  input logic        reset_n,
  input logic [15:0] max_frame_len,
  input logic        tx_frame_done,
  input logic [15:0] tx_frame_len,
  input logic        tx_frame_err,
  input logic        tx_dest_mcast,
  input logic        tx_dest_bcast,
  input logic        tx_frame_ctrl,
  input logic        tx_frame_pause,
  input logic        rx_frame_done,
  input logic [15:0] rx_frame_len,
  input logic        rx_frame_err,
  input logic        rx_dest_mcast,
  input logic        rx_dest_bcast,
  input logic        rx_frame_ctrl,
  input logic        tx_inc_mcast_data_err,
  input logic        tx_inc_fcs_err,
  input logic        tx_inc_pause,
  input logic        tx_inc_fragment,
  input logic        tx_inc_jabber,
  input logic        rx_inc_runt,
  input logic        rx_inc_64,
  input logic        rx_inc_max,
  input logic        rx_inc_over,
  input logic        rx_inc_bcast_data_err,
  input logic        rx_inc_ucast_data_ok
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_mc_err_then_idle;
    tx_frame_done && tx_frame_err && tx_dest_mcast && !tx_dest_bcast && !tx_frame_ctrl ##1 !tx_frame_done;
  endsequence
  sequence s_rx_bc_err;
    rx_frame_done && rx_frame_err && rx_dest_bcast && !rx_frame_ctrl;
  endsequence

  AST_TX_MC_ERR: assert property (s_mc_err_then_idle |-> tx_inc_mcast_data_err ##1 !tx_inc_mcast_data_err)
    else $error("tx multicast error pulse wrong");
  AST_TX_IDLE: assert property (!tx_frame_done |=> !tx_inc_fcs_err && !tx_inc_pause)
    else $error("tx pulse without frame");
  AST_TX_FRAG: assert property (tx_inc_fragment == ($past(tx_frame_done && tx_frame_err) && $past(tx_frame_len) < 16'h0040))
    else $error("tx fragment pulse wrong");
  AST_TX_JABBER: assert property (tx_frame_done && tx_frame_err && tx_frame_len > max_frame_len |=> tx_inc_jabber)
    else $error("tx jabber pulse missing");
  AST_TX_PAUSE: assert property (tx_frame_done && tx_frame_pause |=> tx_inc_pause != $past(tx_frame_err))
    else $error("tx pause pulse wrong");
  AST_RX_RUNT: assert property (rx_frame_done && rx_frame_len < 16'h0040 |=> rx_inc_runt && !rx_inc_64)
    else $error("rx runt pulse wrong");
  AST_RX_MAX: assert property (rx_frame_done && rx_frame_len == max_frame_len |=> rx_inc_max && !rx_inc_over)
    else $error("rx maximum size pulse wrong");
  AST_RX_OVER: assert property (rx_frame_done && rx_frame_len > max_frame_len |=> rx_inc_over && !rx_inc_max)
    else $error("rx oversize pulse wrong");
  AST_RX_BC_ERR: assert property (s_rx_bc_err |=> rx_inc_bcast_data_err && !rx_inc_ucast_data_ok)
    else $error("rx broadcast error pulse wrong");
  AST_RX_UC_OK: assert property (rx_frame_done && !rx_frame_err && !rx_dest_mcast && !rx_dest_bcast
    && !rx_frame_ctrl |=> rx_inc_ucast_data_ok)
    else $error("rx unicast good pulse missing");
endmodule

bind mac_statistics_increment_pulses stat_pulse_checker chk (.*);

//--- dv/stat_counter_model.sv
// Behavioural statistics counters fed by the increment pulses
`timescale 1ns/1ps

// ==========================================================
// Counter bank
module stat_counter_model
#(
  parameter int W = 17
)
(
  input  logic          clk_sys,
  input  logic          reset_n,
  input  logic [W-1:0]  inc,
  output int unsigned   cnt [W]
);
  // Counts every high cycle, so a stretched pulse shows up as an overcount
  always @(posedge clk_sys or negedge reset_n)
  begin
    for (int i = 0; i < W; i++)
      cnt[i] <= !reset_n ? 0 : cnt[i] + inc[i];
  end
endmodule

//--- dv/testbench.sv
// Self-checking testbench for the statistics increment pulses
`timescale 1ns/1ps

// ==========================================================
// Testbench
module testbench;
  logic clk_sys, reset_n, tx_frame_done, tx_frame_err, tx_dest_mcast, tx_dest_bcast, tx_frame_ctrl, tx_frame_pause;
  logic rx_frame_done, rx_frame_err, rx_dest_mcast, rx_dest_bcast, rx_frame_ctrl;
  logic [15:0] max_frame_len, tx_frame_len, rx_frame_len;
  wire [21:0] tv;
  wire [16:0] rv;
  int unsigned cnt [17];
  int unsigned tally [17];
  int errors, samples_checked;
  logic [15:0] lens [16] = '{16'h0028, 16'h003F, 16'h0040, 16'h0041, 16'h007F, 16'h0080, 16'h00FF, 16'h0100,
    16'h01FF, 16'h0200, 16'h03FF, 16'h0400, 16'h05EE, 16'h05EF, 16'h05F0, 16'h05F1};

  mac_statistics_increment_pulses DUT (.clk_sys(clk_sys), .reset_n(reset_n), .max_frame_len(max_frame_len),
    .tx_frame_done(tx_frame_done), .tx_frame_len(tx_frame_len), .tx_frame_err(tx_frame_err),
    .tx_dest_mcast(tx_dest_mcast), .tx_dest_bcast(tx_dest_bcast), .tx_frame_ctrl(tx_frame_ctrl),
    .tx_frame_pause(tx_frame_pause), .rx_frame_done(rx_frame_done), .rx_frame_len(rx_frame_len),
    .rx_frame_err(rx_frame_err), .rx_dest_mcast(rx_dest_mcast), .rx_dest_bcast(rx_dest_bcast),
    .rx_frame_ctrl(rx_frame_ctrl), .tx_inc_64(tv[21]), .tx_inc_127(tv[20]), .tx_inc_255(tv[19]),
    .tx_inc_511(tv[18]), .tx_inc_1023(tv[17]), .tx_inc_1518(tv[16]), .tx_inc_max(tv[15]), .tx_inc_over(tv[14]),
    .tx_inc_mcast_data_err(tv[13]), .tx_inc_mcast_data_ok(tv[12]), .tx_inc_bcast_data_err(tv[11]),
    .tx_inc_bcast_data_ok(tv[10]), .tx_inc_ucast_data_err(tv[9]), .tx_inc_ucast_data_ok(tv[8]),
    .tx_inc_mcast_ctrl(tv[7]), .tx_inc_bcast_ctrl(tv[6]), .tx_inc_ucast_ctrl(tv[5]), .tx_inc_pause(tv[4]),
    .tx_inc_fcs_err(tv[3]), .tx_inc_fragment(tv[2]), .tx_inc_jabber(tv[1]), .tx_inc_sizeok_fcser(tv[0]),
    .rx_inc_runt(rv[16]), .rx_inc_64(rv[15]), .rx_inc_127(rv[14]), .rx_inc_255(rv[13]), .rx_inc_511(rv[12]),
    .rx_inc_1023(rv[11]), .rx_inc_1518(rv[10]), .rx_inc_max(rv[9]), .rx_inc_over(rv[8]),
    .rx_inc_mcast_data_err(rv[7]), .rx_inc_mcast_data_ok(rv[6]), .rx_inc_bcast_data_err(rv[5]),
    .rx_inc_bcast_data_ok(rv[4]), .rx_inc_ucast_data_err(rv[3]), .rx_inc_ucast_data_ok(rv[2]),
    .rx_inc_mcast_ctrl(rv[1]), .rx_inc_bcast_ctrl(rv[0]));

  stat_counter_model #(.W(17)) partner (.clk_sys(clk_sys), .reset_n(reset_n), .inc(rv), .cnt(cnt));

  // ==========================================================
  // Expected pulse sets
  function automatic logic [13:0] base(input logic [15:0] l, input logic e, m, b, c);
    logic mm, u;
    mm = m & ~b;
    u = ~m & ~b;
    base = {l == 16'h0040, l > 16'h0040 && l <= 16'h007F, l > 16'h007F && l <= 16'h00FF, l > 16'h00FF && l <= 16'h01FF,
      l > 16'h01FF && l <= 16'h03FF, l > 16'h03FF && l <= 16'h05EE, l == max_frame_len, l > max_frame_len,
      mm & e & ~c, mm & ~e & ~c, b & e & ~c, b & ~e & ~c, u & e & ~c, u & ~e & ~c};
  endfunction

  function automatic logic [21:0] etx(input logic [15:0] l, input logic e, m, b, c, p);
    etx = {base(l, e, m, b, c), m & ~b & ~e, b & ~e, ~m & ~b & ~e, p & ~e, e, l < 16'h0040 && e,
      l > max_frame_len && e, l >= 16'h0040 && l <= max_frame_len && e};
  endfunction

  // ==========================================================
  // Shared tasks
  task automatic check(input string n, input logic [21:0] seen, input logic [21:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic frame(input logic tx, input logic [15:0] l, input logic e, m, b, c, p);
    logic [16:0] er;
    er = {l < 16'h0040, base(l, e, m, b, c), m & ~b & ~e, b & ~e};
    @(posedge clk_sys);
    if (tx)
      {tx_frame_done, tx_frame_len, tx_frame_err, tx_dest_mcast, tx_dest_bcast, tx_frame_ctrl, tx_frame_pause}
        <= {1'b1, l, e, m, b, c, p};
    else
      {rx_frame_done, rx_frame_len, rx_frame_err, rx_dest_mcast, rx_dest_bcast, rx_frame_ctrl} <= {1'b1, l, e, m, b, c};
    @(posedge clk_sys);
    tx_frame_done <= 1'b0;
    rx_frame_done <= 1'b0;
    #1;
    if (tx)
      check("tx_inc", tv, etx(l, e, m, b, c, p));
    else
    begin
      check("rx_inc", {5'h00, rv}, {5'h00, er});
      for (int i = 0; i < 17; i++)
        tally[i] += er[i];
    end
  endtask

  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_tx_classes;
    for (int i = 0; i < 16; i++)
      frame(1'b1, 16'h0064, i[3], i[2], i[1], i[0], 1'b0);
  endtask

  task automatic t_tx_sizes;
    for (int i = 0; i < 32; i++)
      frame(1'b1, lens[i / 2], i[0], 1'b1, 1'b0, 1'b1, 1'b1);
  endtask

  task automatic t_rx_classes;
    for (int i = 0; i < 16; i++)
      frame(1'b0, 16'h0200, i[3], i[2], i[1], i[0], 1'b0);
  endtask

  task automatic t_rx_sizes;
    for (int i = 0; i < 32; i++)
      frame(1'b0, lens[i / 2], i[0], 1'b0, 1'b0, 1'b0, 1'b0);
    @(posedge clk_sys);
    #1;
    for (int i = 0; i < 17; i++)
      check("rx_count", cnt[i][21:0], tally[i][21:0]);
  endtask

  // Maximum moved onto the top bucket edge: both pulses fire together
  task automatic t_max_moved;
    @(posedge clk_sys);
    max_frame_len <= 16'h05EE;
    #1;
    frame(1'b0, 16'h05EE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    frame(1'b1, 16'h05EF, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
  endtask

  // Reset in mid-pulse clears the RX outputs at once; TX outputs are checked after release
  task automatic t_reset_mid;
    @(posedge clk_sys);
    {rx_frame_done, rx_frame_len, rx_frame_err} <= {1'b1, 16'h0028, 1'b1};
    @(posedge clk_sys);
    rx_frame_done <= 1'b0;
    reset_n <= 1'b0;
    #1;
    check("rst_rx", {5'h00, rv}, 22'h000000);
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1;
    check("rst_tx", tv, 22'h000000);
  endtask

  // Frames on adjacent cycles must not smear into each other
  task automatic t_back_to_back;
    @(posedge clk_sys);
    {tx_frame_done, tx_frame_len, tx_frame_err, tx_dest_mcast, tx_dest_bcast, tx_frame_ctrl, tx_frame_pause}
      <= {1'b1, 16'h0040, 5'b01000};
    @(posedge clk_sys);
    {tx_frame_len, tx_frame_err, tx_dest_bcast} <= {16'h05F1, 2'b11};
    #1;
    check("tx_first", tv, etx(16'h0040, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
    @(posedge clk_sys);
    tx_frame_done <= 1'b0;
    #1;
    check("tx_second", tv, etx(16'h05F1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0));
    @(posedge clk_sys);
    #1;
    check("tx_after", tv, 22'h000000);
  endtask

  // ==========================================================
  // Clock, reset, sequence and watchdog
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial
  begin
    {reset_n, tx_frame_done, tx_frame_err, tx_dest_mcast, tx_dest_bcast, tx_frame_ctrl, tx_frame_pause} = '0;
    {rx_frame_done, rx_frame_err, rx_dest_mcast, rx_dest_bcast, rx_frame_ctrl, tx_frame_len, rx_frame_len} = '0;
    max_frame_len = 16'h05F0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1;
    check("tx_idle", tv, 22'h000000);
    check("rx_idle", {5'h00, rv}, 22'h000000);
    t_tx_classes();
    t_tx_sizes();
    t_rx_classes();
    t_rx_sizes();
    t_max_moved();
    t_back_to_back();
    t_reset_mid();
    report_and_stop();
  end

  // Whole run is a few hundred cycles; this is ample margin
  initial
  begin
    #1000000;
    errors++;
    report_and_stop();
  end
endmodule
